// File: core/cab_pkg.sv
// package of constants for the cpu to at bus control block
// assumes one 200 MHz clock and a synchronous active-high reset
// Functional notes
// - firmware select always asserted for F0000h-FFFFFh.
// - per-32KB firmware select enables for C0000h-EFFFFh region.
// - alias windows near 128MB/256MB select firmware when enabled and dram select high.
// - non-local cycle starts at bus sequencer: address latch first, then command.
// - memory width sampled at the trailing edge of the address latch.
// - i/o width sampled from latch end until command ends.
// - default command wait states are five for 8-bit, one for 16-bit.
// - channel-ready low stretches command; zero-wait request ends it early.
// - exhausted waits end the cycle and raise a ready to the processor side.
// - control bit 2 adds one wait; bit 3 selects single address latch.
// - hold asserted for dma, master, or conventional refresh.
// - refresh strobe or grant only after hold acknowledge.
// - hidden refresh never raises hold.
// - refresh and dma/master granted first come first served.
// - refresh arriving after dma/master is latched and served right after.
// - local device claim sampled end of first T2, second T2 at divide-by-six.
// - speed bit set runs full speed, clear applies slow throttling.
// - slow mode holds cpu for two of every three half-oscillator periods.
package cab_pkg;
    localparam logic [19:0] CAB_FW_BASE    = 20'hf0000;
    localparam logic [3:0]  CAB_ADP_LO     = 4'hc;
    localparam logic [3:0]  CAB_ADP_HI     = 4'he;
    localparam logic [7:0]  CAB_ALIAS_TAG  = 8'hff;
    localparam logic [3:0]  CAB_WAIT_8     = 4'h5;
    localparam logic [3:0]  CAB_WAIT_16    = 4'h1;
    localparam logic [3:0]  CAB_THR_PERIOD = 4'h3;
    localparam logic [3:0]  CAB_THR_HOLD   = 4'h2;

    typedef enum logic [4:0] {
        CAB_AT_IDLE = 5'h01,
        CAB_AT_FIRST_STATE  = 5'h02,
        CAB_AT_COMMAND_STATE   = 5'h04,
        CAB_AT_END  = 5'h08,
        CAB_AT_LOC  = 5'h10
    } cab_at_state_t;

    typedef enum logic [3:0] {
        CAB_ARB_IDLE = 4'h1,
        CAB_ARB_WAIT = 4'h2,
        CAB_ARB_REFRESH_STROBE_N = 4'h4,
        CAB_ARB_DMA  = 4'h8
    } cab_arb_state_t;
endpackage

// File: core/cab_rom_decode.sv
// firmware select decode for low firmware, adapter region and high aliases
// assumes a registered address; output is combinational, registered by the top
module cab_rom_decode
    import cab_pkg::*;
(
    input  wire logic [31:0] addr_i,
    input  wire logic        mem_cycle_i,
    input  wire logic [5:0]  adapter_rom_en_i,
    input  wire logic        alias_rom_en_i,
    input  wire logic        dram_select_n_i,
    output logic             rom_hit_o
);
    logic low_meg;
    logic adp;
    logic [2:0] piece;
    logic alias_hit;

    always_comb begin
        low_meg   = addr_i[31:20] == 12'h000;
        piece     = 3'(addr_i[18:15] - {CAB_ADP_LO[2:0], 1'b0});
        adp       = low_meg && addr_i[19:16] >= CAB_ADP_LO && addr_i[19:16] <= CAB_ADP_HI
                    && adapter_rom_en_i[piece];
        // only 26:19 compared; bit 27 is left free, so both the 128MB and 256MB aliases hit
        alias_hit = alias_rom_en_i && dram_select_n_i
                    && addr_i[26:19] == CAB_ALIAS_TAG;
        rom_hit_o = mem_cycle_i && ((low_meg && addr_i[19:16] == CAB_FW_BASE[19:16])
                    || adp || alias_hit);
    end
endmodule

// File: core/cab_throttle.sv
// slow-mode throttle: periodic hold request timed by half-rate oscillator
// assumes osc_half_clock_i is a synchronous level toggling much slower than mclk_i
module cab_throttle
    import cab_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic osc_half_clock_i,
    input  wire logic full_speed_i,
    output logic      throttle_hold_o
);
    typedef struct packed {
        logic       osc;
        logic [3:0] phase;
        logic       hold;
    } cab_thr_t;
    cab_thr_t s_q;
    cab_thr_t s_d;

    always_comb begin
        s_d     = s_q;
        s_d.osc = osc_half_clock_i;
        if (osc_half_clock_i && !s_q.osc) begin
            s_d.phase = (s_q.phase == CAB_THR_PERIOD - 4'h1) ? 4'h0 : s_q.phase + 4'h1;
        end
        s_d.hold = !full_speed_i && s_d.phase < CAB_THR_HOLD;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign throttle_hold_o = s_q.hold;
endmodule

// File: core/cab_top.sv
// cpu to at bus control: firmware select, at cycle sequencer, hold arbiter
// assumes synchronous inputs, active-low bus pins named with _n
module cab_top
    import cab_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        cyc_start_i,
    input  wire logic        cyc_local_mem_i,
    input  wire logic        cyc_io_i,
    input  wire logic [31:0] cyc_addr_i,
    input  wire logic        dram_select_n_i,
    input  wire logic        mem_width16_n_i,
    input  wire logic        iocs16_n_i,
    input  wire logic        chrdy_i,
    input  wire logic        nows_n_i,
    input  wire logic        ldev_n_i,
    input  wire logic        at_clk_div6_i,
    input  wire logic [5:0]  adapter_rom_en_i,
    input  wire logic        alias_rom_en_i,
    input  wire logic        extra_wait_i,
    input  wire logic        single_ale_i,
    input  wire logic        full_speed_i,
    input  wire logic        hidden_refresh_i,
    input  wire logic        osc_half_clock_i,
    input  wire logic        refresh_req_i,
    input  wire logic        dma_req_i,
    input  wire logic        dma_done_i,
    input  wire logic        hlda_i,
    input  wire logic        rdy_n_i,
    output logic             boot_rom_select_n_o,
    output logic             ale_o,
    output logic             at_cmd_o,
    output logic             at_width16_o,
    output logic             rdy_n_o,
    output logic             rdy_n_oe_o,
    output logic             local_claim_o,
    output logic             hold_o,
    output logic             refresh_strobe_n_o,
    output logic             dma_grant_o,
    output logic             ale_repeat_o
);
    // ***********************************************************
    // state
    // ***********************************************************
    typedef struct packed {
        cab_at_state_t  at;
        cab_arb_state_t arb;
        logic [3:0]     wait_cnt;
        logic           t2_cnt;
        logic           is_io;
        logic           w16;
        logic           rom;
        logic           ale;
        logic           cmd;
        logic           rdy_n;
        logic           rdy_oe;
        logic           claim;
        logic           hold;
        logic           refresh_strobe_n_n;
        logic           grant;
        logic           refresh_strobe_n_pend;
        logic           refresh_strobe_n_after;
        logic           refresh_strobe_n_first;
        logic           ale_rep;
    } cab_top_t;
    cab_top_t s_q;
    cab_top_t s_d;

    logic rom_hit;
    logic thr_hold;
    logic [31:0] addr_q;
    logic        mem_cyc_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            addr_q    <= '0;
            mem_cyc_q <= 1'b0;
        end else if (cyc_start_i) begin
            addr_q    <= cyc_addr_i;
            mem_cyc_q <= !cyc_io_i;
        end
    end

    cab_rom_decode u_rom (
        .addr_i           (addr_q),
        .mem_cycle_i      (mem_cyc_q),
        .adapter_rom_en_i (adapter_rom_en_i),
        .alias_rom_en_i   (alias_rom_en_i),
        .dram_select_n_i  (dram_select_n_i),
        .rom_hit_o        (rom_hit)
    );

    cab_throttle u_thr (
        .mclk_i           (mclk_i),
        .sys_rst_i        (sys_rst_i),
        .osc_half_clock_i (osc_half_clock_i),
        .full_speed_i     (full_speed_i),
        .throttle_hold_o  (thr_hold)
    );

    // ***********************************************************
    // next state
    // ***********************************************************
    always_comb begin
        s_d        = s_q;
        s_d.rdy_n  = 1'b1;
        s_d.rdy_oe = 1'b0;
        s_d.ale    = 1'b0;
        s_d.rom    = 1'b0;
        unique case (s_q.at)
            CAB_AT_IDLE: begin
                if (cyc_start_i && !cyc_local_mem_i) begin
                    s_d.at     = CAB_AT_LOC;
                    s_d.t2_cnt = 1'b0;
                    s_d.is_io  = cyc_io_i;
                end
            end
            CAB_AT_LOC: begin
                // claim window: first T2, or second when bus clock is cpu/6
                if (at_clk_div6_i && !s_q.t2_cnt) begin
                    s_d.t2_cnt = 1'b1;
                end else if (!ldev_n_i) begin
                    s_d.claim = 1'b1;
                    s_d.at    = CAB_AT_END;
                end else begin
                    s_d.at  = CAB_AT_FIRST_STATE;
                    s_d.ale = 1'b1;
                    // select rises with the latch so a select tied back to the width pin reads as 16-bit
                    s_d.rom = rom_hit;
                end
            end
            CAB_AT_FIRST_STATE: begin
                // ale falls now; capture memory width on its trailing edge
                s_d.rom = s_q.rom;
                if (!s_q.is_io) begin
                    s_d.w16 = !mem_width16_n_i;
                end else begin
                    s_d.w16 = !iocs16_n_i;
                end
                s_d.wait_cnt = (s_d.w16 ? CAB_WAIT_16 : CAB_WAIT_8)
                               + {3'h0, extra_wait_i};
                s_d.cmd = 1'b1;
                s_d.at  = CAB_AT_COMMAND_STATE;
            end
            CAB_AT_COMMAND_STATE: begin
                s_d.rom = s_q.rom;
                if (s_q.is_io) begin
                    s_d.w16 = !iocs16_n_i;
                end
                if (!nows_n_i) begin
                    s_d.wait_cnt = 4'h0;
                end else if (chrdy_i && s_q.wait_cnt != 4'h0) begin
                    s_d.wait_cnt = s_q.wait_cnt - 4'h1;
                end
                if ((!nows_n_i || s_q.wait_cnt == 4'h0) && chrdy_i) begin
                    s_d.cmd    = 1'b0;
                    s_d.rdy_n  = 1'b0;
                    s_d.rdy_oe = 1'b1;
                    s_d.at     = CAB_AT_END;
                end
            end
            CAB_AT_END: begin
                // local device terminates its own cycle via the shared ready pin
                if (!s_q.claim || !rdy_n_i) begin
                    s_d.claim = 1'b0;
                    s_d.at    = CAB_AT_IDLE;
                end
            end
            default: s_d.at = CAB_AT_IDLE;
        endcase
        s_d.ale_rep = !single_ale_i;

        // arbiter: refresh strobe and grant only after acknowledge
        if (refresh_req_i && !hidden_refresh_i) begin
            s_d.refresh_strobe_n_pend = 1'b1;
            if (s_q.arb == CAB_ARB_DMA) begin
                s_d.refresh_strobe_n_after = 1'b1;
            end else if (!dma_req_i) begin
                s_d.refresh_strobe_n_first = 1'b1;
            end
        end
        unique case (s_q.arb)
            CAB_ARB_IDLE: begin
                if (s_d.refresh_strobe_n_pend || dma_req_i) begin
                    s_d.arb = CAB_ARB_WAIT;
                end
            end
            CAB_ARB_WAIT: begin
                if (hlda_i) begin
                    if (s_q.refresh_strobe_n_pend && (s_q.refresh_strobe_n_first || !dma_req_i)) begin
                        s_d.arb    = CAB_ARB_REFRESH_STROBE_N;
                        s_d.refresh_strobe_n_n = 1'b0;
                    end else if (dma_req_i) begin
                        s_d.arb   = CAB_ARB_DMA;
                        s_d.grant = 1'b1;
                    end
                end
            end
            CAB_ARB_REFRESH_STROBE_N: begin
                s_d.refresh_strobe_n_n     = 1'b1;
                s_d.refresh_strobe_n_pend  = refresh_req_i && !hidden_refresh_i;
                s_d.refresh_strobe_n_first = 1'b0;
                s_d.refresh_strobe_n_after = 1'b0;
                // a waiting dma keeps hold up instead of dropping it for one cycle
                s_d.arb        = dma_req_i ? CAB_ARB_WAIT : CAB_ARB_IDLE;
            end
            CAB_ARB_DMA: begin
                if (dma_done_i || !dma_req_i) begin
                    s_d.grant = 1'b0;
                    if (s_d.refresh_strobe_n_after) begin
                        s_d.arb    = CAB_ARB_REFRESH_STROBE_N;
                        s_d.refresh_strobe_n_n = 1'b0;
                    end else begin
                        s_d.arb = CAB_ARB_IDLE;
                    end
                end
            end
            default: s_d.arb = CAB_ARB_IDLE;
        endcase
        // hidden refresh never reaches the arbiter, so it never raises hold
        s_d.hold = (s_d.arb != CAB_ARB_IDLE) || thr_hold;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s_q        <= '0;
            s_q.at     <= CAB_AT_IDLE;
            s_q.arb    <= CAB_ARB_IDLE;
            s_q.rdy_n  <= 1'b1;
            s_q.refresh_strobe_n_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ***********************************************************
    // outputs
    // ***********************************************************
    assign boot_rom_select_n_o = !s_q.rom;
    assign ale_o               = s_q.ale;
    assign at_cmd_o            = s_q.cmd;
    assign at_width16_o        = s_q.w16;
    assign rdy_n_o             = s_q.rdy_n;
    assign rdy_n_oe_o          = s_q.rdy_oe;
    assign local_claim_o       = s_q.claim;
    assign hold_o              = s_q.hold;
    assign refresh_strobe_n_o  = s_q.refresh_strobe_n_n;
    assign dma_grant_o         = s_q.grant;
    assign ale_repeat_o        = s_q.ale_rep;
endmodule

// File: tb/cab_top_chk.sv
// concurrent checks on the ports of cab_top
// assumes a single clock domain and sync active-high reset
module cab_top_chk (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic chrdy_i,
    input wire logic nows_n_i,
    input wire logic extra_wait_i,
    input wire logic single_ale_i,
    input wire logic full_speed_i,
    input wire logic hidden_refresh_i,
    input wire logic refresh_req_i,
    input wire logic dma_req_i,
    input wire logic hlda_i,
    input wire logic rdy_n_i,
    input wire logic ale_o,
    input wire logic at_cmd_o,
    input wire logic at_width16_o,
    input wire logic rdy_n_o,
    input wire logic rdy_n_oe_o,
    input wire logic local_claim_o,
    input wire logic hold_o,
    input wire logic refresh_strobe_n_o,
    input wire logic dma_grant_o,
    input wire logic ale_repeat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // command length tracking
    // ****
    logic [3:0] n_q;
    logic       s_q;
    logic       w_q;
    logic       e_q;
    // a stalled or cut-short command is excluded from the length check
    always_ff @(posedge mclk_i) begin
        n_q <= at_cmd_o ? n_q + 4'h1 : 4'h0;
        s_q <= at_cmd_o && (s_q || !chrdy_i || !nows_n_i);
        w_q <= at_width16_o;
        e_q <= extra_wait_i;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // ****
    // properties
    // ****
    property p_ale_first; $rose(at_cmd_o) |-> $past(ale_o); endproperty
    a_ale_first: assert property (p_ale_first) else $error("command without latch");
    property p_wait;
        $fell(at_cmd_o) && !s_q |-> n_q == (w_q ? 4'h2 : 4'h6) + {3'h0, e_q};
    endproperty
    a_wait: assert property (p_wait) else $error("command length wrong");
    property p_rdy; $fell(at_cmd_o) |-> !rdy_n_o && rdy_n_oe_o ##1 rdy_n_o; endproperty
    a_rdy: assert property (p_rdy) else $error("ready pulse wrong");
    property p_hold; $rose(dma_req_i) |=> hold_o; endproperty
    a_hold: assert property (p_hold) else $error("hold not raised");
    property p_ack; $fell(refresh_strobe_n_o) || $rose(dma_grant_o) |-> $past(hlda_i); endproperty
    a_ack: assert property (p_ack) else $error("grant before acknowledge");
    property p_hidden;
        hidden_refresh_i && refresh_req_i && !dma_req_i && full_speed_i && !hold_o |=> !hold_o;
    endproperty
    a_hidden: assert property (p_hidden) else $error("hold on hidden refresh");
    property p_claim; local_claim_o && !rdy_n_i |=> !local_claim_o; endproperty
    a_claim: assert property (p_claim) else $error("claim outlives ready");
    property p_ale1; single_ale_i |=> !ale_repeat_o; endproperty
    a_ale1: assert property (p_ale1) else $error("repeat latch in single mode");
    c_at: cover property ($fell(at_cmd_o));
    c_grant: cover property ($rose(dma_grant_o));
    c_claim: cover property ($rose(local_claim_o));
endmodule

bind cab_top cab_top_chk chk_u (.mclk_i, .sys_rst_i, .chrdy_i, .nows_n_i, .extra_wait_i,
    .single_ale_i, .full_speed_i, .hidden_refresh_i, .refresh_req_i, .dma_req_i, .hlda_i,
    .rdy_n_i, .ale_o, .at_cmd_o, .at_width16_o, .rdy_n_o, .rdy_n_oe_o, .local_claim_o, .hold_o,
    .refresh_strobe_n_o, .dma_grant_o, .ale_repeat_o);

// File: tb/cab_far_model.sv
// processor and local-bus device standing at the far side
// assumes hold and claim come registered from cab_top
module cab_far_model #(
    parameter int ACK_LAT = 2
) (
    input  wire logic mclk_i,
    input  wire logic hold_i,
    input  wire logic claim_i,
    output logic      hlda_o,
    output logic      rdy_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int d_q = 0;
    int c_q = 0;
    initial begin
        hlda_o = 1'b0;
        rdy_n_o = 1'b1;
    end
    // ****
    // behaviour
    // ****
    always @(posedge mclk_i) begin
        // cpu finishes its current cycle before floating the bus
        d_q <= hold_i ? d_q + 1 : 0;
        hlda_o <= hold_i && d_q >= ACK_LAT;
        // released ready pin returns to its pull-up level
        c_q <= (claim_i && rdy_n_o) ? c_q + 1 : 0;
        rdy_n_o <= !(claim_i && c_q == 2);
    end
endmodule

// File: tb/cab_top_test.sv
// self-checking bench for cab_top
// assumes the checker and the far-side model are compiled first
module cab_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, sys_rst_i = 1, cyc_start_i = 0, cyc_local_mem_i = 0, cyc_io_i = 0;
    logic dram_select_n_i = 1, mem_width16_n_i = 1, iocs16_n_i = 1, chrdy_i = 1, nows_n_i = 1;
    logic ldev_n_i = 1, at_clk_div6_i = 0, alias_rom_en_i = 0, extra_wait_i = 0;
    logic single_ale_i = 0, full_speed_i = 1, hidden_refresh_i = 0, osc_half_clock_i = 0;
    logic refresh_req_i = 0, dma_req_i = 0, dma_done_i = 0, hlda_i, rdy_n_i, w, rm, cl;
    logic rom16 = 0;
    logic [31:0] cyc_addr_i = 32'h0;
    logic [5:0]  adapter_rom_en_i = 6'h00;
    logic boot_rom_select_n_o, ale_o, at_cmd_o, at_width16_o, rdy_n_o, rdy_n_oe_o;
    logic local_claim_o, hold_o, refresh_strobe_n_o, dma_grant_o, ale_repeat_o;
    int err_total = 0, checks = 0, oc = 0, n = 0;
    cab_top dut_u (.mclk_i, .sys_rst_i, .cyc_start_i, .cyc_local_mem_i, .cyc_io_i, .cyc_addr_i,
        .dram_select_n_i, .mem_width16_n_i, .iocs16_n_i, .chrdy_i, .nows_n_i, .ldev_n_i,
        .at_clk_div6_i, .adapter_rom_en_i, .alias_rom_en_i, .extra_wait_i, .single_ale_i,
        .full_speed_i, .hidden_refresh_i, .osc_half_clock_i, .refresh_req_i, .dma_req_i,
        .dma_done_i, .hlda_i, .rdy_n_i, .boot_rom_select_n_o, .ale_o, .at_cmd_o, .at_width16_o,
        .rdy_n_o, .rdy_n_oe_o, .local_claim_o, .hold_o, .refresh_strobe_n_o, .dma_grant_o,
        .ale_repeat_o);
    cab_far_model far_u (.mclk_i, .hold_i(hold_o), .claim_i(local_claim_o), .hlda_o(hlda_i),
        .rdy_n_o(rdy_n_i));
    always #2.5 mclk_i = ~mclk_i;
    // slow square wave, period 20 clocks
    always @(negedge mclk_i) begin
        oc = (oc == 9) ? 0 : oc + 1;
        if (oc == 0) osc_half_clock_i = ~osc_half_clock_i;
    end
    // ****
    // helpers
    // ****
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one bus cycle; st cmd cycles with channel not ready, nows low in cmd cycle nw
    task automatic at_cyc(input logic io, input logic [31:0] a, input int st, input int nw);
        n = 0; w = 0; rm = 0; cl = 0;
        cyc_io_i = io; cyc_addr_i = a; cyc_start_i = 1;
        @(negedge mclk_i) cyc_start_i = 0;
        for (int i = 0; i < 40; i++) begin
            @(negedge mclk_i);
            if (at_cmd_o) begin
                n++; w = at_width16_o; rm |= !boot_rom_select_n_o;
            end
            cl |= local_claim_o;
            if (rom16) mem_width16_n_i = boot_rom_select_n_o;
            if (!rdy_n_o || (cl && !local_claim_o)) break;
            chrdy_i = !(at_cmd_o && n <= st);
            nows_n_i = !(at_cmd_o && n == nw);
        end
        chrdy_i = 1; nows_n_i = 1;
        @(negedge mclk_i);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_rom;
        logic [31:0] ad [5] = '{32'h000f_0000, 32'h000e_8000, 32'h000c_0000, 32'h07f8_0000,
            32'h0ff8_0000};
        logic [4:0] ex = 5'h1b;
        adapter_rom_en_i = 6'h20; alias_rom_en_i = 1;
        for (int i = 0; i < 5; i++) begin
            at_cyc(0, ad[i], 0, 0);
            chk("rom_select", rm, ex[i]);
            chk("cmd_len_8", n, 6);
        end
        dram_select_n_i = 0;
        at_cyc(0, ad[3], 0, 0);
        chk("rom_alias_dram", rm, 0);
        dram_select_n_i = 1; alias_rom_en_i = 0;
        at_cyc(0, ad[4], 0, 0);
        chk("rom_alias_off", rm, 0);
        rom16 = 1;
        at_cyc(0, ad[0], 0, 0);
        chk("rom_width16", w, 1);
        chk("rom_len16", n, 2);
        rom16 = 0;
        mem_width16_n_i = 1;
    endtask
    task automatic t_width;
        mem_width16_n_i = 0;
        at_cyc(0, 32'h000d_0000, 0, 0);
        chk("width_mem16", w, 1);
        chk("cmd_len_16", n, 2);
        extra_wait_i = 1;
        at_cyc(0, 32'h000d_0000, 0, 0);
        chk("cmd_len_extra", n, 3);
        extra_wait_i = 0;
        at_cyc(0, 32'h000d_0000, 3, 0);
        chk("cmd_len_stall", n, 5);
        mem_width16_n_i = 1; iocs16_n_i = 0;
        at_cyc(1, 32'h0000_0300, 0, 0);
        chk("width_io16", w, 1);
        iocs16_n_i = 1;
        at_cyc(1, 32'h0000_0300, 0, 0);
        chk("width_io8", w, 0);
        at_cyc(0, 32'h000d_0000, 0, 1);
        chk("nows_short", n < 6, 1);
        single_ale_i = 1;
        repeat (2) @(negedge mclk_i);
        chk("ale_repeat", ale_repeat_o, 0);
        single_ale_i = 0;
        repeat (2) @(negedge mclk_i);
        chk("ale_repeat_on", ale_repeat_o, 1);
    endtask
    task automatic t_local;
        ldev_n_i = 0;
        at_cyc(0, 32'h000a_0000, 0, 0);
        chk("claim", cl, 1);
        chk("claim_no_cmd", n, 0);
        at_clk_div6_i = 1;
        at_cyc(0, 32'h000a_0000, 0, 0);
        chk("claim_div6", cl, 1);
        ldev_n_i = 1; at_clk_div6_i = 0; cyc_local_mem_i = 1;
        at_cyc(0, 32'h0010_0000, 0, 0);
        cyc_local_mem_i = 0;
        chk("local_mem_idle", n + cl, 0);
    endtask
    task automatic t_arb;
        logic hh = 0;
        dma_req_i = 1;
        @(negedge mclk_i);
        chk("hold_dma", hold_o, 1);
        for (int i = 0; i < 20 && !dma_grant_o; i++) @(negedge mclk_i);
        chk("grant", dma_grant_o, 1);
        refresh_req_i = 1;
        repeat (3) @(negedge mclk_i);
        chk("no_preempt", refresh_strobe_n_o, 1);
        dma_done_i = 1; dma_req_i = 0;
        @(negedge mclk_i) dma_done_i = 0;
        for (int i = 0; i < 10 && refresh_strobe_n_o; i++) @(negedge mclk_i);
        chk("queued_refresh", refresh_strobe_n_o, 0);
        refresh_req_i = 0;
        for (int i = 0; i < 20 && hold_o; i++) @(negedge mclk_i);
        chk("hold_release", hold_o, 0);
        refresh_req_i = 1;
        @(negedge mclk_i) dma_req_i = 1;
        for (int i = 0; i < 20 && refresh_strobe_n_o; i++) @(negedge mclk_i);
        chk("refresh_first", dma_grant_o, 0);
        refresh_req_i = 0;
        for (int i = 0; i < 20 && !dma_grant_o; i++) @(negedge mclk_i);
        chk("grant_after", dma_grant_o, 1);
        dma_done_i = 1; dma_req_i = 0;
        @(negedge mclk_i) dma_done_i = 0;
        for (int i = 0; i < 20 && hold_o; i++) @(negedge mclk_i);
        chk("hold_release2", hold_o, 0);
        hidden_refresh_i = 1; refresh_req_i = 1;
        repeat (10) @(negedge mclk_i) hh |= hold_o;
        chk("hidden_no_hold", hh, 0);
        refresh_req_i = 0; hidden_refresh_i = 0;
    endtask
    task automatic t_thr;
        int h = 0;
        full_speed_i = 0;
        repeat (80) @(negedge mclk_i);
        repeat (120) @(negedge mclk_i) h += hold_o;
        chk("slow_hold", h, 80);
        full_speed_i = 1; h = 0;
        repeat (80) @(negedge mclk_i);
        repeat (60) @(negedge mclk_i) h += hold_o;
        chk("full_speed", h, 0);
    endtask
    initial begin
        repeat (8) @(negedge mclk_i);
        sys_rst_i = 0;
        t_rom();
        t_width();
        t_local();
        t_arb();
        t_thr();
        report_and_stop();
    end
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
endmodule
